// *** ftas_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
module ftas_sequencer #(
    parameter int ROW_BYTES = ftas_pkg::ROW_BYTES_SMALL,
    parameter int TIW_CYCLES = ftas_pkg::TIW_CYCLES,
    localparam int IDX_W = $clog2(ROW_BYTES)
) (
    input wire logic CLOCK_I,
    input wire logic RST_B_I,
    input wire logic CE_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic PREADY_O,
    output logic PSLVERR_O,
    output logic [31:0] PRDATA_O,
    output logic STALL_O,
    output logic [20:0] FLASH_RD_WORD_O,
    input wire logic [15:0] FLASH_RD_DATA_I,
    input wire logic [15:0] CFG_RD_DATA_I,
    output logic [ftas_pkg::PTR_W-1:0] FLASH_PROG_ADDR_O,
    output logic [7:0] FLASH_PROG_DATA_O,
    output logic FLASH_PROG_WE_O,
    output logic FLASH_ERASE_O,
    output logic FLASH_CFG_SEL_O
);
    localparam int CNT_W = $clog2(TIW_CYCLES + 1);
    localparam int ROW_W = ftas_pkg::PTR_W - IDX_W;

    logic [ftas_pkg::PTR_W-1:0] ptr_reg;
    logic [ftas_pkg::PTR_W-1:0] ptr_next;
    logic [ftas_pkg::PTR_W-1:0] acc_addr;
    logic [ftas_pkg::PTR_W-1:0] rd_addr_reg;
    logic rd_pend_reg;
    logic [7:0] latch_reg;
    logic pgm_sel_reg, cfg_sel_reg, erase_en_reg, wr_err_reg, wr_en_reg, wr_go_reg;
    logic done_flag_reg;
    logic erase_op_reg;
    ftas_pkg::ftas_unlock_e unlock_reg;
    ftas_pkg::ftas_lw_state_e state_reg;
    logic [CNT_W-1:0] tmr_reg;
    logic [IDX_W-1:0] idx_reg;
    logic [ROW_W-1:0] row_reg;
    logic bus_wr, bus_setup, mapped;
    logic cmd_wr, ctl_wr, start_ok, start_bad;
    ftas_pkg::ftas_ptr_mode_e cmd_mode;
    logic [7:0] sel_byte;
    logic [15:0] sel_word;

    ftas_hold_if #(.IDX_W(IDX_W)) hold ();

    ftas_hold_bank #(.DEPTH(ROW_BYTES)) u_hold (
        .clock_i(CLOCK_I),
        .rst_b_i(RST_B_I),
        .ce_i(CE_I),
        .hold(hold.bank)
    );

    // ========================================
    // apb decode
    assign bus_wr = CE_I && PSEL_I && PENABLE_I && PWRITE_I;
    assign bus_setup = CE_I && PSEL_I && !PENABLE_I;
    assign PREADY_O = 1'b1;

    always_comb begin
        if (PADDR_I == ftas_pkg::OFS_PTR_LOW) begin
            mapped = 1'b1;
        end else if (PADDR_I == ftas_pkg::OFS_PTR_HIGH) begin
            mapped = 1'b1;
        end else if (PADDR_I == ftas_pkg::OFS_PTR_UPPER) begin
            mapped = 1'b1;
        end else if (PADDR_I == ftas_pkg::OFS_LATCH) begin
            mapped = 1'b1;
        end else if (PADDR_I == ftas_pkg::OFS_MEM_CTRL) begin
            mapped = 1'b1;
        end else if (PADDR_I == ftas_pkg::OFS_UNLOCK) begin
            mapped = 1'b1;
        end else if (PADDR_I == ftas_pkg::OFS_PERIPH_FLAG) begin
            mapped = 1'b1;
        end else if (PADDR_I == ftas_pkg::OFS_TABLE_CMD) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;

    // read data captured in the setup cycle, shown in the access cycle
    always_ff @(posedge CLOCK_I) begin
        if (!RST_B_I) begin
            PRDATA_O <= 32'h0000_0000;
        end else if (bus_setup) begin
            PRDATA_O <= 32'h0000_0000;
            if (PADDR_I == ftas_pkg::OFS_PTR_LOW) begin
                PRDATA_O[7:0] <= ptr_reg[7:0];
            end else if (PADDR_I == ftas_pkg::OFS_PTR_HIGH) begin
                PRDATA_O[7:0] <= ptr_reg[15:8];
            end else if (PADDR_I == ftas_pkg::OFS_PTR_UPPER) begin
                PRDATA_O[5:0] <= ptr_reg[21:16];
            end else if (PADDR_I == ftas_pkg::OFS_LATCH) begin
                PRDATA_O[7:0] <= latch_reg;
            end else if (PADDR_I == ftas_pkg::OFS_MEM_CTRL) begin
                PRDATA_O[ftas_pkg::CTL_PGM_SEL] <= pgm_sel_reg;
                PRDATA_O[ftas_pkg::CTL_CFG_SEL] <= cfg_sel_reg;
                PRDATA_O[ftas_pkg::CTL_ERASE_EN] <= erase_en_reg;
                PRDATA_O[ftas_pkg::CTL_WR_ERR] <= wr_err_reg;
                PRDATA_O[ftas_pkg::CTL_WR_EN] <= wr_en_reg;
                PRDATA_O[ftas_pkg::CTL_WR_GO] <= wr_go_reg;
            end else if (PADDR_I == ftas_pkg::OFS_PERIPH_FLAG) begin
                PRDATA_O[ftas_pkg::FLAG_WR_DONE] <= done_flag_reg;
            end else if (PADDR_I == ftas_pkg::OFS_TABLE_CMD) begin
                PRDATA_O[0] <= rd_pend_reg;
            end
        end
    end

    // ========================================
    // table operations
    assign cmd_wr = bus_wr && (PADDR_I == ftas_pkg::OFS_TABLE_CMD) &&
        (state_reg == ftas_pkg::LW_IDLE);
    assign cmd_mode = ftas_pkg::ftas_ptr_mode_e'(PWDATA_I[ftas_pkg::CMD_MODE_LSB +: 2]);

    always_comb begin
        acc_addr = ptr_reg;
        ptr_next = ptr_reg;
        case (cmd_mode)
            ftas_pkg::PTR_POST_INC: begin
                ptr_next[20:0] = ptr_reg[20:0] + 21'h00_0001;
            end
            ftas_pkg::PTR_POST_DEC: begin
                ptr_next[20:0] = ptr_reg[20:0] - 21'h00_0001;
            end
            ftas_pkg::PTR_PRE_INC: begin
                ptr_next[20:0] = ptr_reg[20:0] + 21'h00_0001;
                acc_addr = ptr_next;
            end
            default: begin
                ptr_next = ptr_reg;
            end
        endcase
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RST_B_I) begin
            ptr_reg <= 22'h00_0000;
        end else if (cmd_wr) begin
            ptr_reg <= ptr_next;
        end else if (bus_wr && PADDR_I == ftas_pkg::OFS_PTR_LOW) begin
            ptr_reg[7:0] <= PWDATA_I[7:0];
        end else if (bus_wr && PADDR_I == ftas_pkg::OFS_PTR_HIGH) begin
            ptr_reg[15:8] <= PWDATA_I[7:0];
        end else if (bus_wr && PADDR_I == ftas_pkg::OFS_PTR_UPPER) begin
            ptr_reg[21:16] <= PWDATA_I[5:0];
        end
    end

    // read address held one cycle while the array answers
    always_ff @(posedge CLOCK_I) begin
        if (!RST_B_I) begin
            rd_addr_reg <= 22'h00_0000;
            rd_pend_reg <= 1'b0;
        end else if (CE_I) begin
            rd_pend_reg <= cmd_wr && !PWDATA_I[ftas_pkg::CMD_DIR];
            if (cmd_wr) begin
                rd_addr_reg <= acc_addr;
            end
        end
    end

    assign FLASH_RD_WORD_O = rd_addr_reg[21:1];
    assign sel_word = rd_addr_reg[ftas_pkg::SPACE_BIT] ? CFG_RD_DATA_I
        : FLASH_RD_DATA_I;
    assign sel_byte = rd_addr_reg[0] ? sel_word[15:8] : sel_word[7:0];

    always_ff @(posedge CLOCK_I) begin
        if (!RST_B_I) begin
            latch_reg <= 8'h00;
        end else if (CE_I && rd_pend_reg) begin
            latch_reg <= sel_byte;
        end else if (bus_wr && PADDR_I == ftas_pkg::OFS_LATCH) begin
            latch_reg <= PWDATA_I[7:0];
        end
    end

    // table write only fills the holding bytes
    assign hold.wr_en = cmd_wr && PWDATA_I[ftas_pkg::CMD_DIR];
    assign hold.wr_idx = acc_addr[IDX_W-1:0];
    assign hold.wr_data = latch_reg;
    assign hold.rd_idx = idx_reg;
    assign hold.clear_all = (state_reg == ftas_pkg::LW_DONE);

    // ========================================
    // unlock and start
    assign ctl_wr = bus_wr && (PADDR_I == ftas_pkg::OFS_MEM_CTRL);
    assign start_ok = ctl_wr && PWDATA_I[ftas_pkg::CTL_WR_GO] && PWDATA_I[ftas_pkg::CTL_WR_EN] &&
        PWDATA_I[ftas_pkg::CTL_PGM_SEL] && (unlock_reg == ftas_pkg::UL_ARMED) &&
        (state_reg == ftas_pkg::LW_IDLE);
    assign start_bad = ctl_wr && PWDATA_I[ftas_pkg::CTL_WR_GO] &&
        !PWDATA_I[ftas_pkg::CTL_WR_EN] && (state_reg == ftas_pkg::LW_IDLE);

    always_ff @(posedge CLOCK_I) begin
        if (!RST_B_I) begin
            unlock_reg <= ftas_pkg::UL_IDLE;
        end else if (bus_wr) begin
            if (PADDR_I != ftas_pkg::OFS_UNLOCK) begin
                unlock_reg <= ftas_pkg::UL_IDLE;
            end else if (PWDATA_I[7:0] == ftas_pkg::UNLOCK_FIRST) begin
                unlock_reg <= ftas_pkg::UL_GOT_FIRST;
            end else if (PWDATA_I[7:0] == ftas_pkg::UNLOCK_SECOND &&
                    unlock_reg == ftas_pkg::UL_GOT_FIRST) begin
                unlock_reg <= ftas_pkg::UL_ARMED;
            end else begin
                unlock_reg <= ftas_pkg::UL_IDLE;
            end
        end
    end

    // control bits; hardware set/clear takes priority over software
    always_ff @(posedge CLOCK_I) begin
        if (!RST_B_I) begin
            pgm_sel_reg <= 1'b0;
            cfg_sel_reg <= 1'b0;
            erase_en_reg <= 1'b0;
            wr_en_reg <= 1'b0;
            wr_go_reg <= 1'b0;
            wr_err_reg <= ftas_pkg::WRITE_ERROR_FLAG_RESET[0];
            erase_op_reg <= 1'b0;
        end else if (CE_I) begin
            if (ctl_wr && state_reg == ftas_pkg::LW_IDLE) begin
                pgm_sel_reg <= PWDATA_I[ftas_pkg::CTL_PGM_SEL];
                cfg_sel_reg <= PWDATA_I[ftas_pkg::CTL_CFG_SEL];
                erase_en_reg <= PWDATA_I[ftas_pkg::CTL_ERASE_EN];
                wr_en_reg <= PWDATA_I[ftas_pkg::CTL_WR_EN];
                wr_err_reg <= PWDATA_I[ftas_pkg::CTL_WR_ERR];
            end
            if (start_ok) begin
                wr_go_reg <= 1'b1;
                wr_err_reg <= 1'b1;
                erase_op_reg <= PWDATA_I[ftas_pkg::CTL_ERASE_EN];
            end else if (start_bad) begin
                wr_err_reg <= 1'b1;
            end else if (state_reg == ftas_pkg::LW_DONE) begin
                wr_go_reg <= 1'b0;
                wr_err_reg <= 1'b0;
                if (erase_op_reg) begin
                    erase_en_reg <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RST_B_I) begin
            done_flag_reg <= 1'b0;
        end else if (CE_I && state_reg == ftas_pkg::LW_DONE) begin
            done_flag_reg <= 1'b1;
        end else if (bus_wr && PADDR_I == ftas_pkg::OFS_PERIPH_FLAG) begin
            done_flag_reg <= PWDATA_I[ftas_pkg::FLAG_WR_DONE];
        end
    end

    // ========================================
    // self-timed long write
    always_ff @(posedge CLOCK_I) begin
        if (!RST_B_I) begin
            state_reg <= ftas_pkg::LW_IDLE;
            tmr_reg <= '0;
            idx_reg <= '0;
            row_reg <= '0;
        end else if (CE_I) begin
            if (tmr_reg != '0) begin
                tmr_reg <= tmr_reg - CNT_W'(1);
            end
            case (state_reg)
                ftas_pkg::LW_IDLE: begin
                    if (start_ok) begin
                        state_reg <= ftas_pkg::LW_RUN;
                        tmr_reg <= CNT_W'(TIW_CYCLES - 1);
                        idx_reg <= '0;
                        row_reg <= ptr_reg[ftas_pkg::PTR_W-1:IDX_W];
                    end
                end
                ftas_pkg::LW_RUN: begin
                    idx_reg <= idx_reg + IDX_W'(1);
                    if (erase_op_reg || idx_reg == IDX_W'(ROW_BYTES - 1)) begin
                        state_reg <= ftas_pkg::LW_WAIT;
                    end
                end
                ftas_pkg::LW_WAIT: begin
                    if (tmr_reg == '0) begin
                        state_reg <= ftas_pkg::LW_DONE;
                    end
                end
                default: begin
                    state_reg <= ftas_pkg::LW_IDLE;
                end
            endcase
        end
    end

    assign STALL_O = (state_reg != ftas_pkg::LW_IDLE);

    // array strobes registered from the running row
    always_ff @(posedge CLOCK_I) begin
        if (!RST_B_I) begin
            FLASH_PROG_ADDR_O <= 22'h00_0000;
            FLASH_PROG_DATA_O <= 8'hFF;
            FLASH_PROG_WE_O <= 1'b0;
            FLASH_ERASE_O <= 1'b0;
            FLASH_CFG_SEL_O <= 1'b0;
        end else if (CE_I) begin
            FLASH_CFG_SEL_O <= cfg_sel_reg;
            FLASH_PROG_WE_O <= 1'b0;
            FLASH_ERASE_O <= 1'b0;
            if (state_reg == ftas_pkg::LW_RUN) begin
                if (erase_op_reg) begin
                    FLASH_PROG_ADDR_O <= {row_reg, IDX_W'(0)};
                    FLASH_ERASE_O <= 1'b1;
                end else begin
                    FLASH_PROG_ADDR_O <= {row_reg, idx_reg};
                    FLASH_PROG_DATA_O <= hold.rd_data;
                    FLASH_PROG_WE_O <= (hold.rd_data != ftas_pkg::HOLD_RESET);
                end
            end
        end
    end

    // ========================================
    // checks
    AST_PTR_TOP_KEPT: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        cmd_wr |=> ptr_reg[ftas_pkg::SPACE_BIT] == $past(ptr_reg[ftas_pkg::SPACE_BIT]))
        else $error("pointer top bit changed by a table op");
    AST_READ_TO_LATCH: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        (CE_I && rd_pend_reg) |=> latch_reg == $past(sel_byte))
        else $error("table read did not load the latch");
    AST_STALL_WHILE_BUSY: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        start_ok |=> STALL_O throughout (wr_go_reg [*2]))
        else $error("no stall during long write");
    AST_GO_CLEARED: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        (CE_I && state_reg == ftas_pkg::LW_DONE) |=> !wr_go_reg && !STALL_O)
        else $error("write-go not cleared at completion");
    AST_ERASE_EN_CLEARED: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        (CE_I && state_reg == ftas_pkg::LW_DONE && erase_op_reg) |=> !erase_en_reg)
        else $error("erase enable not cleared");
    AST_DONE_FLAG_SET: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        (CE_I && state_reg == ftas_pkg::LW_DONE) |=> done_flag_reg)
        else $error("write-done flag not set");
    AST_NO_START_UNARMED: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        (ctl_wr && unlock_reg != ftas_pkg::UL_ARMED && state_reg == ftas_pkg::LW_IDLE)
        |=> state_reg == ftas_pkg::LW_IDLE)
        else $error("long write started without unlock");
    AST_IMPROPER_ERR: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        start_bad |=> wr_err_reg && !wr_go_reg && state_reg == ftas_pkg::LW_IDLE)
        else $error("improper attempt not flagged");
    AST_SKIP_ERASED_BYTE: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        FLASH_PROG_WE_O |-> FLASH_PROG_DATA_O != ftas_pkg::HOLD_RESET)
        else $error("FFh byte was programmed");
    AST_ERASE_ROW_ALIGNED: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        FLASH_ERASE_O |-> FLASH_PROG_ADDR_O[IDX_W-1:0] == '0 && !FLASH_PROG_WE_O)
        else $error("erase address not row aligned");
endmodule // ftas_sequencer
`default_nettype wire

// *** ftas_pkg.sv ***
`default_nettype none
package ftas_pkg;
    // ========================================
    // register byte offsets
    localparam logic [7:0] OFS_PTR_LOW = 8'h00;
    localparam logic [7:0] OFS_PTR_HIGH = 8'h04;
    localparam logic [7:0] OFS_PTR_UPPER = 8'h08;
    localparam logic [7:0] OFS_LATCH = 8'h0C;
    localparam logic [7:0] OFS_MEM_CTRL = 8'h10;
    localparam logic [7:0] OFS_UNLOCK = 8'h14;
    localparam logic [7:0] OFS_PERIPH_FLAG = 8'h18;
    localparam logic [7:0] OFS_TABLE_CMD = 8'h1C;
    // ========================================
    // memory control and peripheral flag fields
    localparam int CTL_PGM_SEL = 7;
    localparam int CTL_CFG_SEL = 6;
    localparam int CTL_ERASE_EN = 4;
    localparam int CTL_WR_ERR = 3;
    localparam int CTL_WR_EN = 2;
    localparam int CTL_WR_GO = 1;
    localparam int FLAG_WR_DONE = 4;
    // table command fields
    localparam int CMD_DIR = 0;
    localparam int CMD_MODE_LSB = 1;
    // ========================================
    // pointer geometry, unlock codes and reset values
    localparam int PTR_W = 22;
    localparam int PTR_CNT_W = 21;
    localparam int SPACE_BIT = 21;
    localparam int ROW_BYTES_SMALL = 64;
    localparam logic [7:0] UNLOCK_FIRST = 8'h55;
    localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
    localparam logic [7:0] HOLD_RESET = 8'hFF;
    localparam logic [7:0] WRITE_ERROR_FLAG_RESET = 8'h01;
    // ========================================
    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int TIW_NS = 1000000;
    localparam int TIW_CYCLES = TIW_NS / CLK_PERIOD_NS;
    // ========================================
    typedef enum logic [1:0] {
        PTR_KEEP = 2'h0,
        PTR_POST_INC = 2'h1,
        PTR_POST_DEC = 2'h2,
        PTR_PRE_INC = 2'h3
    } ftas_ptr_mode_e;
    typedef enum logic [1:0] {
        LW_IDLE = 2'h0,
        LW_RUN = 2'h1,
        LW_WAIT = 2'h3,
        LW_DONE = 2'h2
    } ftas_lw_state_e;
    typedef enum logic [1:0] {
        UL_IDLE = 2'h0,
        UL_GOT_FIRST = 2'h1,
        UL_ARMED = 2'h3
    } ftas_unlock_e;
endpackage
`default_nettype wire

// *** ftas_hold_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface ftas_hold_if #(parameter int IDX_W = 6);
    logic wr_en;
    logic [IDX_W-1:0] wr_idx;
    logic [7:0] wr_data;
    logic [IDX_W-1:0] rd_idx;
    logic [7:0] rd_data;
    logic clear_all;
    modport ctrl (output wr_en, wr_idx, wr_data, rd_idx, clear_all, input rd_data);
    modport bank (input wr_en, wr_idx, wr_data, rd_idx, clear_all, output rd_data);
endinterface
`default_nettype wire

// *** ftas_hold_bank.sv ***
`timescale 1ns/1ps
`default_nettype none
module ftas_hold_bank #(
    parameter int DEPTH = 64
) (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    ftas_hold_if.bank hold
);
    logic [7:0] mem_reg [DEPTH];

    // ========================================
    // holding bytes, back to erased value on reset and after each long write
    always_ff @(posedge clock_i) begin
        if (!rst_b_i || (ce_i && hold.clear_all)) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= ftas_pkg::HOLD_RESET;
            end
        end else if (ce_i && hold.wr_en) begin
            mem_reg[hold.wr_idx] <= hold.wr_data;
        end
    end

    assign hold.rd_data = mem_reg[hold.rd_idx];
endmodule // ftas_hold_bank
`default_nettype wire

// *** ftas_flash_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ========================================
// flash array stand-in: erase fills a row, programming only clears bits
module ftas_flash_model (
    input wire logic clock_i,
    input wire logic [20:0] rd_word_i,
    output logic [15:0] rd_data_o,
    input wire logic [21:0] prog_addr_i,
    input wire logic [7:0] prog_data_i,
    input wire logic prog_we_i,
    input wire logic erase_i
);
    logic [15:0] mem [0:1023];
    wire logic [9:0] pw = prog_addr_i[10:1];
    wire logic [3:0] pb = {prog_addr_i[0], 3'h0};
    initial for (int i = 0; i < 1024; i++) mem[i] = 16'h5A3C ^ 16'(i);
    assign rd_data_o = mem[rd_word_i[9:0]];
    always @(posedge clock_i) begin
        if (erase_i) for (int i = 0; i < 32; i++) mem[{pw[9:5], 5'(i)}] <= 16'hFFFF;
        if (prog_we_i) mem[pw][pb +: 8] <= mem[pw][pb +: 8] & prog_data_i;
    end
endmodule // ftas_flash_model
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk, rst_b, psel, pen, pwr, serr, ce;
    logic [7:0] pa, b, o;
    logic [31:0] pwd, rd, r;
    logic [15:0] cfg;
    logic [21:0] p, q, a;
    logic [7:0] ex [0:4];
    wire logic pready, perr, stall, we, er, csel;
    wire logic [31:0] prd;
    wire logic [20:0] rw;
    wire logic [15:0] fd;
    wire logic [21:0] pga;
    wire logic [7:0] pgd;
    int miscompares, checked;
    logic [31:0] lfsr = 32'h4257_FB3B;
    ftas_sequencer #(.ROW_BYTES(64), .TIW_CYCLES(80)) u_ftas_sequencer (.CLOCK_I(clk),
        .RST_B_I(rst_b), .CE_I(ce), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(pa), .PWDATA_I(pwd), .PREADY_O(pready), .PSLVERR_O(perr), .PRDATA_O(prd),
        .STALL_O(stall), .FLASH_RD_WORD_O(rw), .FLASH_RD_DATA_I(fd), .CFG_RD_DATA_I(cfg),
        .FLASH_PROG_ADDR_O(pga), .FLASH_PROG_DATA_O(pgd), .FLASH_PROG_WE_O(we),
        .FLASH_ERASE_O(er), .FLASH_CFG_SEL_O(csel));
    ftas_flash_model u_ftas_flash_model (.clock_i(clk), .rd_word_i(rw), .rd_data_o(fd),
        .prog_addr_i(pga), .prog_data_i(pgd), .prog_we_i(we), .erase_i(er));
    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    function automatic logic [7:0] exb(input logic [21:0] x);
        if (x[21]) return x[0] ? cfg[15:8] : cfg[7:0];
        return u_ftas_flash_model.mem[x[10:1]][{x[0], 3'h0} +: 8];
    endfunction
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pen <= 0;
        pwr <= w;
        pa <= ad;
        pwd <= d;
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prd;
        serr = perr;
        psel <= 0;
        pen <= 0;
    endtask
    task automatic setp(input logic [21:0] x);
        apb(1, ftas_pkg::OFS_PTR_UPPER, {26'h0, x[21:16]});
        apb(1, ftas_pkg::OFS_PTR_HIGH, {24'h0, x[15:8]});
        apb(1, ftas_pkg::OFS_PTR_LOW, {24'h0, x[7:0]});
    endtask
    task automatic tread(input logic [1:0] m);
        apb(1, ftas_pkg::OFS_TABLE_CMD, {29'h0, m, 1'b0});
        repeat (2) @(posedge clk);
        apb(0, ftas_pkg::OFS_LATCH, 0);
        b = rd[7:0];
    endtask
    task automatic lw(input logic [7:0] c, input logic s);
        apb(1, ftas_pkg::OFS_UNLOCK, {24'h0, ftas_pkg::UNLOCK_FIRST});
        apb(1, ftas_pkg::OFS_UNLOCK, {24'h0, ftas_pkg::UNLOCK_SECOND});
        apb(1, ftas_pkg::OFS_MEM_CTRL, {24'h0, c});
        @(posedge clk);
        #1 chk("stall", stall, s);
        for (int i = 0; i < 200 && stall; i++) @(posedge clk);
        #1 chk("stall_end", stall, 0);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        summarize();
    end
    initial begin
        {psel, pen, pwr, pa, pwd, rst_b} = 0;
        ce = 1;
        cfg = 16'hC3A5;
        repeat (10) @(posedge clk);
        rst_b <= 1;
        apb(0, ftas_pkg::OFS_MEM_CTRL, 0);
        chk("ctrl_reset", rd, 32'h08);
        apb(0, 8'h20, 0);
        chk("unmapped", serr, 1);
        for (int m = 0; m < 4; m++) for (int k = 0; k < 3; k++) begin
            r = rnd();
            cfg <= r[31:16];
            p = k == 0 ? 22'h3F_FFFF : k == 1 ? 22'h20_0000 : {11'h0, r[10:0]};
            setp(p);
            a = m == 3 ? {p[21], p[20:0] + 21'h1} : p;
            tread(m[1:0]);
            chk("latch", b, exb(a));
            q = m == 2 ? {p[21], p[20:0] - 21'h1} : m == 0 ? p : {p[21], p[20:0] + 21'h1};
            apb(0, ftas_pkg::OFS_PTR_UPPER, 0);
            p[21:16] = rd[5:0];
            apb(0, ftas_pkg::OFS_PTR_HIGH, 0);
            p[15:8] = rd[7:0];
            apb(0, ftas_pkg::OFS_PTR_LOW, 0);
            chk("pointer", {p[21:8], rd[7:0]}, q);
        end
        $display("test pointer done");
        r = rnd();
        p = {11'h1, r[10:0]};
        setp(p);
        lw(8'h96, 1);
        apb(0, ftas_pkg::OFS_MEM_CTRL, 0);
        chk("ctrl_erase", rd, 32'h84);
        apb(0, ftas_pkg::OFS_PERIPH_FLAG, 0);
        chk("done_flag", rd[4], 1);
        for (int j = 0; j < 64; j += 63) begin
            setp({p[21:6], 6'(j)});
            tread(0);
            chk("erased", b, 8'hFF);
        end
        $display("test erase done");
        for (int i = 0; i < 5; i++) ex[i] = 8'hFF;
        for (int t = 0; t < 2; t++) begin
            setp({p[21:6], 6'h0});
            for (int i = 0; i < 4 - 3 * t; i++) begin
                r = rnd();
                if (i == 0) o = ex[0];
                ex[i] = ex[i] & r[7:0];
                apb(1, ftas_pkg::OFS_LATCH, {24'h0, r[7:0]});
                apb(1, ftas_pkg::OFS_TABLE_CMD, 32'h3);
            end
            setp({p[21:6], 6'h0});
            tread(0);
            chk("short_write", b, o);
            lw(8'h86, 1);
            for (int i = 0; i < 5; i++) begin
                setp({p[21:6], 6'(i)});
                tread(0);
                chk("programmed", b, ex[i]);
            end
        end
        $display("test program done");
        apb(1, ftas_pkg::OFS_MEM_CTRL, 32'h86);
        @(posedge clk);
        #1 chk("no_unlock", stall, 0);
        lw(8'h82, 0);
        apb(0, ftas_pkg::OFS_MEM_CTRL, 0);
        chk("improper", rd[3:1], 3'b100);
        apb(1, ftas_pkg::OFS_MEM_CTRL, 32'h40);
        @(posedge clk);
        #1 chk("cfg_sel", csel, 1);
        ce <= 0;
        apb(1, ftas_pkg::OFS_PTR_LOW, 32'h5A);
        ce <= 1;
        apb(0, ftas_pkg::OFS_PTR_LOW, 0);
        chk("ce_freeze", rd, {24'h0, p[7:6], 6'h04});
        $display("test guard done");
        apb(1, ftas_pkg::OFS_UNLOCK, {24'h0, ftas_pkg::UNLOCK_FIRST});
        apb(1, ftas_pkg::OFS_UNLOCK, {24'h0, ftas_pkg::UNLOCK_SECOND});
        apb(1, ftas_pkg::OFS_MEM_CTRL, 32'h86);
        repeat (3) @(posedge clk);
        rst_b <= 0;
        repeat (2) @(posedge clk);
        rst_b <= 1;
        apb(0, ftas_pkg::OFS_MEM_CTRL, 0);
        chk("reset_cut", {stall, rd[7:0]}, 9'h008);
        $display("test reset done");
        summarize();
    end
endmodule // tb
`default_nettype wire
